// ---- ext_bus_hold_handshake.v ----
// Summary of operation
// (RL1) Pending bus transfers finish before the hold grant is asserted.
// (RL2) Bus floats no sooner than two interface periods after request low.
// (RL3) Grant goes low within zero to two periods after bus floats.
// (RL4) Master keeps request low one period after grant; device relies on it.
// (RL5) Bus driven again two to seven periods after request returns high.
// (RL6) Grant goes high within zero to two periods after bus driven.
// (RL7) Float option 0 keeps output clock running; 1 floats it in hold.
// (RL8) With float option, clock floats and returns like the bus.
// (RL9) Hold-disable bit set withholds the grant indefinitely.
// (RL10) All bus outputs float together; wide instance also floats clock enable.
// (RL11) Latencies count interface clock periods: external, core/4 or core/6.
// (RL12) Bus floats in reset; driven no sooner than sixteen periods after.
// (RL13) In reset pending request low and grant mirrors hold request.
// (RL14) Hold request passes two flip-flops before the state machine.

`include "hold_defs.vh"

module ext_bus_hold_handshake #(
  parameter WIDE = 1
) (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    ce,
  input  wire [1:0]              clk_sel,
  input  wire                    ext_bus_clock_in,
  input  wire                    hold_req_n,
  input  wire                    hold_grant_disable,
  input  wire                    clock_out_float_select,
  input  wire                    xfer_pending,
  input  wire                    xfer_busy,
  input  wire                    int_clock_out,
  input  wire [`CE_W-1:0]        int_ce_n,
  input  wire [`WIDE_BE_W-1:0]   int_be_n,
  input  wire [`WIDE_DATA_W-1:0] int_data,
  input  wire [`WIDE_ADDR_W-1:0] int_addr,
  input  wire [2:0]              int_strobe_n,
  input  wire                    int_third_output_enable_n,
  input  wire                    int_direct_transfer_strobe_n,
  input  wire                    int_sync_clock_enable,
  output reg                     bus_hold_grant_n,
  output reg                     bus_pending_request,
  output reg                     xfer_stall,
  output reg                     ext_bus_clock_out,
  output reg                     ext_bus_clock_out_oe,
  output reg  [`CE_W-1:0]        ce_n_out,
  output reg  [`WIDE_BE_W-1:0]   be_n_out,
  output reg  [`WIDE_DATA_W-1:0] data_out,
  output reg  [`WIDE_ADDR_W-1:0] addr_out,
  output reg  [2:0]              strobe_n_out,
  output reg                     third_output_enable_n,
  output reg                     direct_transfer_strobe_n,
  output reg                     sync_clock_enable,
  output reg                     bus_oe
);

  // ----------------------------------------
  // State encoding
  // ----------------------------------------
  localparam [5:0] ST_RESET   = 6'h01;
  localparam [5:0] ST_OWN     = 6'h02;
  localparam [5:0] ST_DRAIN   = 6'h04;
  localparam [5:0] ST_FLOAT   = 6'h08;
  localparam [5:0] ST_HELD    = 6'h10;
  localparam [5:0] ST_RESUME  = 6'h20;

  localparam [`WIDE_BE_W-1:0]   BE_MASK   = WIDE ? {`WIDE_BE_W{1'b1}} : {{(`WIDE_BE_W-`NARROW_BE_W){1'b0}},
                                                                        {`NARROW_BE_W{1'b1}}};
  localparam [`WIDE_DATA_W-1:0] DATA_MASK = WIDE ? {`WIDE_DATA_W{1'b1}} :
                                            {{(`WIDE_DATA_W-`NARROW_DATA_W){1'b0}}, {`NARROW_DATA_W{1'b1}}};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        hreq_s1_q;
  reg        hreq_s2_q;
  reg [5:0]  state_q;
  reg [5:0]  state_d;
  reg [4:0]  cnt_q;
  reg [4:0]  cnt_d;
  reg        oe_d;
  reg        grant_n_d;
  reg        clk_oe_d;
  wire       tick;

  // ----------------------------------------
  // Interface clock tick
  // ----------------------------------------
  iclk_tick_gen u_tick (
    .clk              (clk),
    .rst              (rst),
    .ce               (ce),
    .clk_sel          (clk_sel),
    .ext_bus_clock_in (ext_bus_clock_in),
    .tick_q           (tick)
  );

  // ----------------------------------------
  // Request synchroniser
  // ----------------------------------------
  always @(posedge clk) begin
    if (ce) begin
      hreq_s1_q  <= hold_req_n; // RL14
      hreq_s2_q  <= hreq_s1_q; // RL14
    end
  end

  // ----------------------------------------
  // Arbitration state machine
  // ----------------------------------------
  always @* begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    oe_d      = bus_oe;
    grant_n_d = bus_hold_grant_n;
    clk_oe_d  = ext_bus_clock_out_oe;
    case (state_q)
      ST_RESET: begin
        oe_d     = 1'b0; // RL12
        clk_oe_d = 1'b0;
        if (tick) begin
          cnt_d = cnt_q + 5'h1;
          if (cnt_q >= `RESET_DRIVE_MIN_E) begin // RL12
            state_d  = ST_OWN;
            oe_d     = 1'b1;
            clk_oe_d = 1'b1;
            cnt_d    = 5'h0;
          end
        end
      end
      ST_OWN: begin
        grant_n_d = 1'b1;
        if (!hreq_s2_q && !hold_grant_disable) begin // RL9
          state_d = ST_DRAIN;
          cnt_d   = 5'h0;
        end
      end
      ST_DRAIN: begin
        if (hreq_s2_q) begin
          state_d = ST_OWN;
        end else if (tick) begin
          if (cnt_q < {1'b0, `FLOAT_MIN_E})
            cnt_d = cnt_q + 5'h1;
          if (cnt_q >= {1'b0, `FLOAT_MIN_E} && !xfer_pending && !xfer_busy &&
              !hold_grant_disable) begin // RL1 RL2 RL9
            state_d = ST_FLOAT;
            oe_d    = 1'b0; // RL10
            if (clock_out_float_select)
              clk_oe_d = 1'b0; // RL7 RL8
            cnt_d   = 5'h0;
          end
        end
      end
      ST_FLOAT: begin
        if (tick) begin
          state_d   = ST_HELD;
          grant_n_d = 1'b0; // RL3
        end
      end
      ST_HELD: begin
        if (hreq_s2_q) begin // RL4
          state_d = ST_RESUME;
          cnt_d   = 5'h0;
        end
      end
      ST_RESUME: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h1;
          if (cnt_q >= {1'b0, `RESUME_MIN_E}) begin // RL5
            state_d  = ST_OWN;
            oe_d     = 1'b1;
            clk_oe_d = 1'b1; // RL8
            cnt_d    = 5'h0;
          end
        end
      end
      default: begin
        state_d = ST_RESET;
        cnt_d   = 5'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q              <= ST_RESET;
      cnt_q                <= 5'h0;
      bus_oe               <= 1'b0; // RL12
      ext_bus_clock_out_oe <= 1'b0;
      bus_hold_grant_n     <= hreq_s2_q; // RL13
      bus_pending_request  <= 1'b0; // RL13
      xfer_stall           <= 1'b1;
    end else if (ce) begin
      state_q              <= state_d;
      cnt_q                <= cnt_d;
      bus_oe               <= oe_d;
      ext_bus_clock_out_oe <= clk_oe_d;
      if (state_q == ST_RESET)
        bus_hold_grant_n <= hreq_s2_q; // RL13
      else if (state_q == ST_OWN && state_d == ST_OWN)
        bus_hold_grant_n <= 1'b1; // RL6
      else
        bus_hold_grant_n <= grant_n_d;
      bus_pending_request  <= (state_q != ST_RESET) && xfer_pending && !bus_oe;
      xfer_stall           <= (state_d != ST_OWN) && !(state_d == ST_DRAIN && xfer_busy); // RL1
    end
  end

  // ----------------------------------------
  // Pad output registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ext_bus_clock_out        <= 1'b0;
      ce_n_out                 <= {`CE_W{1'b1}};
      be_n_out                 <= {`WIDE_BE_W{1'b1}};
      data_out                 <= {`WIDE_DATA_W{1'b0}};
      addr_out                 <= {`WIDE_ADDR_W{1'b0}};
      strobe_n_out             <= 3'h7;
      third_output_enable_n    <= 1'b1;
      direct_transfer_strobe_n <= 1'b1;
      sync_clock_enable        <= 1'b0;
    end else if (ce) begin
      ext_bus_clock_out        <= int_clock_out; // RL7
      ce_n_out                 <= int_ce_n;
      be_n_out                 <= int_be_n & BE_MASK; // RL10
      data_out                 <= int_data & DATA_MASK; // RL10
      addr_out                 <= int_addr;
      strobe_n_out             <= int_strobe_n;
      third_output_enable_n    <= int_third_output_enable_n;
      direct_transfer_strobe_n <= int_direct_transfer_strobe_n;
      sync_clock_enable        <= WIDE ? int_sync_clock_enable : 1'b0; // RL10
    end
  end

endmodule // ext_bus_hold_handshake

// ---- hold_defs.vh ----
`ifndef HOLD_DEFS_VH
`define HOLD_DEFS_VH

// ----------------------------------------
// Interface clock selection
// ----------------------------------------
`define ICLK_SEL_EXT      2'h0
`define ICLK_SEL_DIV4     2'h1
`define ICLK_SEL_DIV6     2'h2
`define DIV4_RELOAD       3'h3
`define DIV6_RELOAD       3'h5

// ----------------------------------------
// Latencies in interface clock periods
// ----------------------------------------
`define FLOAT_MIN_E       4'h2
`define GRANT_MAX_E       4'h2
`define RESUME_MIN_E      4'h2
`define RESUME_MAX_E      4'h7
`define RELEASE_MAX_E     4'h2
`define RESET_DRIVE_MIN_E 5'h10

// ----------------------------------------
// Widths of the two instances
// ----------------------------------------
`define WIDE_DATA_W       64
`define WIDE_BE_W         8
`define WIDE_ADDR_W       20
`define NARROW_DATA_W     16
`define NARROW_BE_W       2
`define NARROW_ADDR_W     20
`define CE_W              4

`endif

// ---- iclk_tick_gen.v ----
`include "hold_defs.vh"

// ----------------------------------------
// Interface clock tick: one pulse per period
// ----------------------------------------
module iclk_tick_gen (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire [1:0] clk_sel,
  input  wire       ext_bus_clock_in,
  output reg        tick_q
);

  reg       ext_s1_q;
  reg       ext_s2_q;
  reg       ext_s3_q;
  reg [2:0] div_q;
  reg [2:0] reload;

  always @* begin
    reload = (clk_sel == `ICLK_SEL_DIV6) ? `DIV6_RELOAD : `DIV4_RELOAD;
  end

  always @(posedge clk) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      div_q    <= 3'h0;
      tick_q   <= 1'b0;
    end else if (ce) begin
      ext_s1_q <= ext_bus_clock_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (div_q == 3'h0)
        div_q <= reload;
      else
        div_q <= div_q - 3'h1;
      if (clk_sel == `ICLK_SEL_EXT)
        tick_q <= ext_s2_q & ~ext_s3_q; // RL11
      else
        tick_q <= (div_q == 3'h0); // RL11
    end
  end

endmodule // iclk_tick_gen

// ---- ext_bus_hold_handshake_checker.sv ----
module ext_bus_hold_handshake_checker (
  input logic clk,
  input logic rst,
  input logic hold_req_n,
  input logic hold_grant_disable,
  input logic clock_out_float_select,
  input logic xfer_pending,
  input logic xfer_busy,
  input logic bus_hold_grant_n,
  input logic xfer_stall,
  input logic ext_bus_clock_out_oe,
  input logic bus_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Handshake steps
  // ----------------------------------------
  sequence s_still_driving;
    bus_oe [*8];
  endsequence
  sequence s_resume;
    !bus_oe [*8] ##[1:40] bus_oe;
  endsequence
  a_float_min: assert property (bus_oe && $fell(hold_req_n) |-> s_still_driving) else $error("bus floated early");
  a_drain_first: assert property ($fell(bus_oe) |-> $past(!xfer_busy && !xfer_pending)) else $error("float mid transfer");
  a_grant_floated: assert property ($fell(bus_hold_grant_n) |-> !bus_oe) else $error("grant before float");
  a_grant_soon: assert property ($fell(bus_oe) |-> ##[0:12] !bus_hold_grant_n) else $error("grant late");
  a_resume_window: assert property ($rose(hold_req_n) && !bus_hold_grant_n |-> s_resume) else $error("resume off");
  a_release_soon: assert property ($rose(bus_oe) |-> ##[0:8] bus_hold_grant_n) else $error("release late");
  a_release_order: assert property ($rose(bus_hold_grant_n) |-> bus_oe) else $error("release before drive");
  a_no_grant: assert property (hold_grant_disable && bus_hold_grant_n |=> bus_hold_grant_n) else $error("granted");
  a_clock_hold: assert property (!bus_hold_grant_n && !bus_oe && $stable(clock_out_float_select)
    |-> ext_bus_clock_out_oe == !clock_out_float_select) else $error("clock oe wrong");
  a_reset_quiet: assert property ($fell(rst) |-> !bus_oe [*8]) else $error("drove soon after reset");
  a_sync_two: assert property (bus_oe && !xfer_stall && $fell(hold_req_n) |-> !xfer_stall [*2]) else $error("no sync");
endmodule // ext_bus_hold_handshake_checker

bind ext_bus_hold_handshake ext_bus_hold_handshake_checker u_ext_bus_hold_handshake_checker (.clk, .rst, .hold_req_n,
  .hold_grant_disable, .clock_out_float_select, .xfer_pending, .xfer_busy, .bus_hold_grant_n, .xfer_stall,
  .ext_bus_clock_out_oe, .bus_oe);

// ---- hold_master.sv ----
module hold_master (
  input  logic clk,
  input  logic want,
  input  logic bus_hold_grant_n,
  output logic hold_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] held = 4'h0;
  initial hold_req_n = 1'b1;
  // Request moves only after falling edges
  always @(negedge clk) begin
    if (bus_hold_grant_n) held <= 4'h0;
    else if (held != 4'hf) held <= held + 4'h1;
    if (want) hold_req_n <= 1'b0;
    else if (bus_hold_grant_n || held >= 4'h9) hold_req_n <= 1'b1;
  end
endmodule // hold_master

// ---- ext_bus_hold_handshake_tb.sv ----
module ext_bus_hold_handshake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] sel; logic fl; logic dis; logic g; logic co;} row_t;
  row_t rows [5] = '{'{2'h1, 0, 0, 0, 1}, '{2'h1, 1, 0, 0, 0}, '{2'h2, 0, 0, 0, 1}, '{2'h0, 1, 0, 0, 0},
                     '{2'h1, 1, 1, 1, 1}};
  logic        clk = 1'b0, ext_clk = 1'b0, rst = 1'b1, want = 1'b0, hold_req_n;
  logic [1:0]  clk_sel = 2'h1;
  logic        grant_dis = 1'b0, float_sel = 1'b0, pend = 1'b0, busy = 1'b0;
  logic [63:0] wdata = 64'h0, dout;
  logic        grant_n, pend_req, stall, ck_oe, bus_oe, ck_out;
  logic [19:0] aout;
  logic [2:0]  sout;
  int          miscompares = 0, n_checks = 0, n;
  always #25 clk = ~clk;
  always #175 ext_clk = ~ext_clk;
  hold_master u_hold_master (.clk(clk), .want(want), .bus_hold_grant_n(grant_n), .hold_req_n(hold_req_n));
  ext_bus_hold_handshake #(.WIDE(1)) u_ext_bus_hold_handshake (.clk(clk), .rst(rst), .ce(1'b1),
    .clk_sel(clk_sel), .ext_bus_clock_in(ext_clk), .hold_req_n(hold_req_n), .hold_grant_disable(grant_dis),
    .clock_out_float_select(float_sel), .xfer_pending(pend), .xfer_busy(busy), .int_clock_out(wdata[38]),
    .int_ce_n(wdata[3:0]), .int_be_n(wdata[11:4]), .int_data(wdata), .int_addr(wdata[31:12]),
    .int_strobe_n(wdata[34:32]), .int_third_output_enable_n(wdata[35]), .int_direct_transfer_strobe_n(wdata[36]),
    .int_sync_clock_enable(wdata[37]), .bus_hold_grant_n(grant_n), .bus_pending_request(pend_req),
    .xfer_stall(stall), .ext_bus_clock_out(ck_out), .ext_bus_clock_out_oe(ck_oe), .ce_n_out(), .be_n_out(),
    .data_out(dout), .addr_out(aout), .strobe_n_out(sout), .third_output_enable_n(), .direct_transfer_strobe_n(),
    .sync_clock_enable(), .bus_oe(bus_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait on grant (0) or bus enable (1); must = a timeout is fatal
  task automatic wait_on(input bit which, input logic lvl, input int lim, input bit must, output int cnt);
    cnt = 0;
    while (((which ? bus_oe : grant_n) !== lvl) && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (must && cnt == lim) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    chk("oe_in_reset", 0, bus_oe);
    chk("pend_in_reset", 0, pend_req);
    chk("grant_in_reset", hold_req_n, grant_n);
    rst = 1'b0;
    wait_on(1, 1, 200, 1, n);
    chk("drive_delay", 1, n >= 64);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      clk_sel = rows[i].sel;
      float_sel = rows[i].fl;
      grant_dis = rows[i].dis;
      wdata = 64'h0123456789abcdef + 64'(i);
      repeat (4) @(negedge clk);
      chk("data", wdata, dout);
      chk("addr", wdata[31:12], aout);
      chk("strobe", wdata[34:32], sout);
      chk("clk_out", wdata[38], ck_out);
      want = 1'b1;
      wait_on(0, 0, 100, !rows[i].dis, n);
      repeat (2) @(negedge clk);
      chk("grant", rows[i].g, grant_n);
      chk("bus_oe", rows[i].g, bus_oe);
      chk("clk_oe", rows[i].co, ck_oe);
      want = 1'b0;
      wait_on(0, 1, 100, 1, n);
      repeat (2) @(negedge clk);
      chk("oe_back", 1, bus_oe);
    end
    clk_sel = 2'h1;
    grant_dis = 1'b0;
    busy = 1'b1;
    want = 1'b1;
    repeat (40) @(negedge clk);
    chk("drain_oe", 1, bus_oe);
    busy = 1'b0;
    wait_on(0, 0, 100, 1, n);
    pend = 1'b1;
    repeat (2) @(negedge clk);
    chk("pend_held", 1, pend_req);
    pend = 1'b0;
    want = 1'b0;
    wait_on(0, 1, 100, 1, n);
    want = 1'b1;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    chk("grant_mirror", 0, grant_n);
    want = 1'b0;
    repeat (12) @(negedge clk);
    do_reset();
    report_and_stop();
  end
endmodule // ext_bus_hold_handshake_tb
